//--- hdl/eals_pkg.sv
// package: constants and carrier types for effective-address and load/store unit
package eals_pkg;
  // instruction field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int REG_HI = 11;
  localparam int REG_LO = 10;
  localparam int XSF_HI = 9;
  localparam int XSF_LO = 8;
  localparam int DSP_HI = 7;
  localparam int DSP_LO = 0;
  // index-select encodings
  localparam logic [1:0] XS_BASE = 2'h0;
  localparam logic [1:0] XS_PCREL = 2'h1;
  localparam logic [1:0] XS_ACC2 = 2'h2;
  localparam logic [1:0] XS_ACC3 = 2'h3;
  // memory-reference opcodes
  localparam logic [3:0] OP_LOAD = 4'h8;
  localparam logic [3:0] OP_LOAD_IND = 4'h9;
  localparam logic [3:0] OP_STORE = 4'hA;
  localparam logic [3:0] OP_STORE_IND = 4'hB;
  // pointer base for the level-0 interrupt indirect jump
  localparam logic [15:0] LVL0_PTR_BASE = 16'h0120;
  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  // address-formation request
  typedef struct packed {
    logic [15:0] instr;     // first instruction word
    logic [15:0] disp_word; // second word of a double-word instruction
    logic dbl_word;         // request uses the 16-bit displacement form
    logic lvl0_jump;        // level-0 interrupt indirect jump
    logic [15:0] pc;        // program counter per address-formation point
  } eals_req_t;
  // memory bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } eals_mem_t;
  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001,
    SQ_PTR = 5'b00010,
    SQ_OPER = 5'b00100,
    SQ_WAIT = 5'b01000,
    SQ_DONE = 5'b10000
  } eals_state_t;
endpackage : eals_pkg

//--- hdl/eals_unit.sv
// effective-address formation and load/store execution unit
module eals_unit
  import eals_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,         // one-cycle request strobe
  input wire eals_req_t req_i,      // instruction, displacement word, pc
  input wire logic [15:0] mem_rdata_i, // read data from memory bus
  input wire logic mem_ack_i,       // memory cycle complete
  output eals_mem_t mem_o,          // memory bus request, held until ack
  output logic [15:0] eff_addr_o,   // final operand address
  output logic [15:0] jump_tgt_o,   // level-0 jump target
  output logic [15:0] acc0_o,
  output logic [15:0] acc1_o,
  output logic [15:0] acc2_o,
  output logic [15:0] acc3_o,
  output logic busy_o,
  output logic done_o               // one-cycle completion pulse
);
  // ------------------------------------------------------------
  // address formation (combinational)
  // ------------------------------------------------------------
  logic [15:0] acc_r [4];           // accumulator file
  logic [15:0] acc_nxt [4];
  logic [3:0] opc;
  logic [1:0] xsel;
  logic [1:0] rsel;
  logic [15:0] disp_ext;            // widened displacement
  logic [15:0] addend;              // base added to displacement
  logic [15:0] eff_addr_direct;     // address before any indirection
  assign opc = req_i.instr[OPC_HI:OPC_LO];
  assign xsel = req_i.instr[XSF_HI:XSF_LO];
  assign rsel = req_i.instr[REG_HI:REG_LO];

  // select displacement width and base register
  always_comb begin
    if (req_i.dbl_word) begin
      disp_ext = req_i.disp_word;
    end else if (xsel == XS_BASE) begin
      disp_ext = {8'h00, req_i.instr[DSP_HI:DSP_LO]};
    end else begin
      disp_ext = {{8{req_i.instr[DSP_HI]}}, req_i.instr[DSP_HI:DSP_LO]};
    end
    unique case (xsel)
      XS_BASE: addend = WORD_RST;
      // caller supplies pc already advanced, or pointing at disp word
      XS_PCREL: addend = req_i.pc;
      XS_ACC2: addend = acc_r[2];
      XS_ACC3: addend = acc_r[3];
    endcase
    // carry out of bit 15 is simply dropped
    eff_addr_direct = disp_ext + addend;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  eals_state_t state_r, state_nxt;
  eals_mem_t mem_r, mem_nxt;
  logic [15:0] eff_addr_r, eff_addr_nxt;
  logic [15:0] jt_r, jt_nxt;
  logic [1:0] rsel_r, rsel_nxt;
  logic is_load_r, is_load_nxt;
  logic is_jump_r, is_jump_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;           // own flop, so busy_o needs no decode
  logic is_mem_op;
  assign is_mem_op = (opc == OP_LOAD) || (opc == OP_LOAD_IND) ||
                     (opc == OP_STORE) || (opc == OP_STORE_IND);

  // next-state and bus request computation
  always_comb begin
    state_nxt = state_r;
    mem_nxt = mem_r;
    eff_addr_nxt = eff_addr_r;
    jt_nxt = jt_r;
    rsel_nxt = rsel_r;
    is_load_nxt = is_load_r;
    is_jump_nxt = is_jump_r;
    done_nxt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc_nxt[i] = acc_r[i];
    end
    unique case (state_r)
      SQ_IDLE: begin
        if (start_i && req_i.lvl0_jump) begin
          // pointer location from fixed base, then target read
          eff_addr_nxt = LVL0_PTR_BASE + {8'h00, req_i.instr[DSP_HI:DSP_LO]};
          is_jump_nxt = 1'b1;
          mem_nxt = '{rd: 1'b1, wr: 1'b0, addr: eff_addr_nxt, wdata: WORD_RST};
          state_nxt = SQ_PTR;
        end else if (start_i && is_mem_op) begin
          eff_addr_nxt = eff_addr_direct;
          rsel_nxt = rsel;
          is_jump_nxt = 1'b0;
          is_load_nxt = ~opc[1];
          if (opc[0]) begin
            // only the indirect opcodes fetch a pointer
            mem_nxt = '{rd: 1'b1, wr: 1'b0, addr: eff_addr_direct,
                        wdata: WORD_RST};
            state_nxt = SQ_PTR;
          end else begin
            mem_nxt = '{rd: ~opc[1], wr: opc[1], addr: eff_addr_direct,
                        wdata: acc_r[rsel]};
            state_nxt = SQ_WAIT;
          end
        end
      end
      SQ_PTR: begin
        if (mem_ack_i) begin
          // pointer word becomes the operand address, unmodified
          eff_addr_nxt = mem_rdata_i;
          mem_nxt = '{rd: 1'b0, wr: 1'b0, addr: mem_r.addr, wdata: WORD_RST};
          if (is_jump_r) begin
            jt_nxt = mem_rdata_i;
            done_nxt = 1'b1;
            state_nxt = SQ_IDLE;
          end else begin
            state_nxt = SQ_OPER;
          end
        end
      end
      SQ_OPER: begin
        // one dead cycle between bus cycles keeps the strobes distinct
        mem_nxt = '{rd: is_load_r, wr: ~is_load_r, addr: eff_addr_r,
                    wdata: acc_r[rsel_r]};
        state_nxt = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (mem_ack_i) begin
          if (mem_r.rd) begin
            acc_nxt[rsel_r] = mem_rdata_i;
          end
          mem_nxt = '{rd: 1'b0, wr: 1'b0, addr: mem_r.addr, wdata: WORD_RST};
          state_nxt = SQ_DONE;
        end
      end
      SQ_DONE: begin
        done_nxt = 1'b1;
        state_nxt = SQ_IDLE;
      end
      default: state_nxt = SQ_IDLE;
    endcase
    // busy follows the state being entered, so the output is a plain flop
    busy_nxt = (state_nxt != SQ_IDLE);
  end

  // state registers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= SQ_IDLE;
      mem_r <= '0;
      eff_addr_r <= WORD_RST;
      jt_r <= WORD_RST;
      rsel_r <= 2'h0;
      is_load_r <= 1'b0;
      is_jump_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= WORD_RST;
      end
    end else begin
      state_r <= state_nxt;
      mem_r <= mem_nxt;
      eff_addr_r <= eff_addr_nxt;
      jt_r <= jt_nxt;
      rsel_r <= rsel_nxt;
      is_load_r <= is_load_nxt;
      is_jump_r <= is_jump_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= acc_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign mem_o = mem_r;
  assign eff_addr_o = eff_addr_r;
  assign jump_tgt_o = jt_r;
  assign acc0_o = acc_r[0];
  assign acc1_o = acc_r[1];
  assign acc2_o = acc_r[2];
  assign acc3_o = acc_r[3];
  assign busy_o = busy_r;
  assign done_o = done_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_idle_start;
    state_r == SQ_IDLE && start_i && !req_i.lvl0_jump;
  endsequence

  chk_base_page: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_idle_start and (!req_i.dbl_word && xsel == XS_BASE && is_mem_op && !opc[0]))
    |=> mem_r.addr == {8'h00, $past(req_i.instr[7:0])})
    else $error("base page address wrong");
  chk_pc_rel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_idle_start and (xsel == XS_PCREL && is_mem_op && !opc[0] && !req_i.dbl_word))
    |=> mem_r.addr == 16'($past(req_i.pc) + {{8{$past(req_i.instr[7])}},
                                               $past(req_i.instr[7:0])}))
    else $error("pc relative address wrong");
  chk_dbl_word: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_idle_start and (req_i.dbl_word && xsel == XS_BASE && is_mem_op))
    |=> mem_r.addr == $past(req_i.disp_word))
    else $error("double word address wrong");
  chk_index_acc: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_idle_start and (xsel == XS_ACC3 && !req_i.dbl_word && is_mem_op))
    |=> mem_r.addr == 16'($past(acc_r[3]) + {{8{$past(req_i.instr[7])}},
                                              $past(req_i.instr[7:0])}))
    else $error("indexed address wrong");
  chk_lvl0_ptr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_r == SQ_IDLE && start_i && req_i.lvl0_jump
    |=> mem_r.rd && mem_r.addr == 16'(LVL0_PTR_BASE + $past(req_i.instr[7:0])))
    else $error("level-0 pointer address wrong");
  chk_ind_ptr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_r == SQ_PTR && mem_ack_i && !is_jump_r
    |=> ##1 mem_r.addr == $past(mem_rdata_i, 2))
    else $error("indirect operand address wrong");
  chk_direct_no_ptr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s_idle_start and (is_mem_op && !opc[0])) |=> state_r == SQ_WAIT)
    else $error("direct op fetched a pointer");
  chk_store_keep: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_r == SQ_WAIT && mem_r.wr && mem_ack_i
    |=> acc_r[rsel_r] == $past(acc_r[rsel_r]) && mem_r.wdata == WORD_RST)
    else $error("store altered accumulator");
  // write data must track the chosen accumulator for the whole bus cycle
  chk_store_data: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_r == SQ_WAIT && mem_r.wr |-> mem_r.wdata == acc_r[rsel_r])
    else $error("store data differs from accumulator");
  chk_load_data: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_r == SQ_WAIT && mem_r.rd && mem_ack_i
    |=> acc_r[rsel_r] == $past(mem_rdata_i) ##1 done_r)
    else $error("load result wrong");
endmodule // eals_unit

//--- tb/eals_mem_model.sv
// main-memory partner model answering the unit's bus cycles
module eals_mem_model
  import eals_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire eals_mem_t mem_i,  // request from the unit
  input wire logic [1:0] dly_i, // wait states before answering
  output logic [15:0] rdata_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [65536];        // whole address space, seeded below
  logic [1:0] cnt_r;               // wait states spent
  // ----------------------------------------
  // answer logic
  // ----------------------------------------
  // fixed array rather than a sparse one: simpler tools take it as is
  initial for (int i = 0; i < 65536; i++) mem[i] = 16'(i) ^ 16'h5A3C;
  // untouched words read as address xor a pattern, so every word differs;
  // data turns to its inverse after the answer so stale values never match
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      cnt_r <= 2'h0;
      rdata_o <= 16'h0000;
    end else if ((mem_i.rd || mem_i.wr) && !ack_o && cnt_r == dly_i) begin
      ack_o <= 1'b1;
      cnt_r <= 2'h0;
      rdata_o <= mem[mem_i.addr];
      if (mem_i.wr) mem[mem_i.addr] <= mem_i.wdata;
    end else begin
      ack_o <= 1'b0;
      if ((mem_i.rd || mem_i.wr) && !ack_o) cnt_r <= cnt_r + 2'h1;
      if (ack_o) rdata_o <= ~rdata_o;
    end
  end
endmodule // eals_mem_model

//--- tb/tb_top.sv
// self-checking bench for the address and load/store unit
module tb_top
  import eals_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic start_i = 1'b0;
  eals_req_t req_i = '0;
  eals_mem_t mem_o;
  logic [15:0] mem_rdata_i, eff_addr_o, jump_tgt_o, acc0_o, acc1_o, acc2_o, acc3_o;
  logic mem_ack_i, busy_o, done_o;
  logic [1:0] dly = 2'h0;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 65;
  logic [15:0] acc [4] = '{default: 16'h0000}; // expected accumulators
  logic [15:0] shadow [logic [15:0]];           // expected written words
  eals_unit dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_i), .req_i(req_i),
    .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .mem_o(mem_o), .eff_addr_o(eff_addr_o),
    .jump_tgt_o(jump_tgt_o), .acc0_o(acc0_o), .acc1_o(acc1_o), .acc2_o(acc2_o),
    .acc3_o(acc3_o), .busy_o(busy_o), .done_o(done_o));
  eals_mem_model mem (.clock_i(clock_i), .rst_b_i(rst_b_i), .mem_i(mem_o), .dly_i(dly),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic [15:0] rd_mem(logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : a ^ 16'h5A3C;
  endfunction
  function automatic logic [15:0] calc_addr(logic [15:0] ins, logic dbl, logic [15:0] dw,
      logic [15:0] pc);
    logic [15:0] off;
    off = dbl ? dw : {{8{ins[7]}}, ins[7:0]};
    case (ins[9:8])
      2'h0: return dbl ? dw : {8'h00, ins[7:0]};
      2'h1: return pc + off;
      2'h2: return acc[2] + off;
      default: return acc[3] + off;
    endcase
  endfunction
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one request, a refused start while busy, then all comparisons
  task automatic run(logic [3:0] op, logic [1:0] r, logic [1:0] xs, logic [7:0] d,
      logic dbl, logic [15:0] dw, logic [15:0] pc, logic lv);
    int n;
    int rv;
    logic [15:0] addr;
    @(negedge clock_i);
    rv = $random(seed);
    dly = rv[1:0];
    req_i = '{instr: {op, r, xs, d}, disp_word: dw, dbl_word: dbl, lvl0_jump: lv, pc: pc};
    @(negedge clock_i);
    start_i = 1'b1;
    @(negedge clock_i);
    req_i.instr = {4'h8, ~r, ~xs, ~d}; // must be ignored while busy
    @(negedge clock_i);
    start_i = 1'b0;
    for (n = 0; n < 80 && done_o !== 1'b1; n++) @(negedge clock_i);
    check("done", 16'h0001, {15'h0000, done_o});
    if (lv) begin
      check("jump", rd_mem(16'h0120 + {8'h00, d}), jump_tgt_o);
    end else begin
      addr = calc_addr({op, r, xs, d}, dbl, dw, pc);
      if (op[0]) addr = rd_mem(addr);
      if (op[1]) shadow[addr] = acc[r];
      else acc[r] = rd_mem(addr);
      check("eff_addr", addr, eff_addr_o);
    end
    check("acc0", acc[0], acc0_o);
    check("acc1", acc[1], acc1_o);
    check("acc2", acc[2], acc2_o);
    check("acc3", acc[3], acc3_o);
    $display("test op %h mode %h done", op, xs);
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial forever #2.5 clock_i = ~clock_i;
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end
  initial begin
    int k;
    int rv;
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    check("reset acc", 16'h0000, acc0_o);
    run(4'h8, 2'h2, 2'h0, 8'h40, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h8, 2'h3, 2'h0, 8'hFF, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'hA, 2'h2, 2'h0, 8'h10, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h8, 2'h0, 2'h0, 8'h10, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h8, 2'h1, 2'h1, 8'h01, 1'b0, 16'h0000, 16'hFFFF, 1'b0);
    run(4'h8, 2'h0, 2'h3, 8'h80, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h8, 2'h1, 2'h0, 8'h00, 1'b1, 16'hBEEF, 16'h1000, 1'b0);
    run(4'h9, 2'h1, 2'h1, 8'h00, 1'b1, 16'hFFF0, 16'h0020, 1'b0);
    run(4'hB, 2'h0, 2'h2, 8'h7F, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h9, 2'h3, 2'h2, 8'h7F, 1'b0, 16'h0000, 16'h1000, 1'b0);
    run(4'h8, 2'h0, 2'h0, 8'hFF, 1'b0, 16'h0000, 16'h1000, 1'b1);
    @(negedge clock_i);
    req_i = '{instr: 16'hC123, disp_word: 16'h0000, dbl_word: 1'b0, lvl0_jump: 1'b0, pc: 16'h0};
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    check("ignored", 16'h0000, {15'h0000, busy_o});
    for (k = 0; k < 40; k++) begin
      rv = $random(seed);
      run({2'h2, rv[1:0]}, rv[3:2], rv[5:4], rv[13:6], rv[14], rv[31:16], rv[30:15],
        1'b0);
    end
    give_verdict();
  end
endmodule // tb_top
